// *** rtl/dscp_top.sv ***
// serial command port: frame shifter, commit decode, registers and readback
`timescale 1ns/100ps
`default_nettype none
`include "dscp_defs.svh"
module dscp_top (
  input  wire logic                          sys_clk_i,     // system clock
  input  wire logic                          rstn_i,        // synchronous reset, low
  input  wire logic                          sclk_i,        // link clock from host
  input  wire logic                          sdi_i,         // serial data in
  input  wire logic                          latch_i,       // frame commit strobe
  input  wire logic [`DSCP_STATUS_BITS-1:0]  status_i,      // fault and slew flags
  output logic                               sdo_o,         // serial data out
  output logic [15:0]                        data_o,        // converter data
  output logic [15:0]                        ctrl_o,        // control
  output logic [15:0]                        cfg_o,         // configuration
  output logic [15:0]                        gain_o,        // gain calibration
  output logic [15:0]                        zero_o,        // zero calibration
  output logic                               wdt_restart_o, // watchdog restart pulse
  output logic                               crc_clear_o,   // crc fault clear pulse
  output logic                               soft_reset_o   // software reset pulse
);
  import dscp_pkg::*;

  // keeps bits below the converter resolution at zero
  localparam logic [15:0] DATA_MASK = 16'hffff << (16 - `DSCP_RES_BITS);
  // fastest link clock the port is built for, in MHz; the readback path
  // runs from cnt on the rising edge through a subtract and a mux to sdo
  // on the falling edge, so that half period of logic also bounds the limit
  localparam int SCLK_MAX_MHZ = `DSCP_SCLK_MAX_MHZ;

  dscp_sys_t sys_q;  // system domain state
  dscp_sys_t sys_d;  // its next value
  dscp_lnk_t lnk_q;  // link rising edge state
  dscp_lnk_t lnk_d;  // its next value
  dscp_neg_t neg_q;  // link falling edge state
  dscp_neg_t neg_d;  // its next value

  logic [7:0]  addr;   // address byte of the frame in the shifter
  logic [15:0] word;   // data word of the frame in the shifter
  logic [15:0] wdata;  // converter data as it would be stored
  logic [23:0] rd_frm; // readback frame seen by the link side
  logic [4:0]  rd_idx; // bit of rd_frm driven at this falling edge

  // picks the register named by a read select code
  function automatic logic [15:0] rd_pick(input logic [5:0] sel,
                                          input dscp_sys_t s,
                                          input logic [15:0] st);
    logic [15:0] r;
    r = `DSCP_REG_RESET;
    if (sel == `DSCP_SEL_CFG) begin
      r = s.cfg;
    end else if (sel == `DSCP_SEL_GAIN) begin
      r = s.gain;
    end else if (sel == `DSCP_SEL_ZERO) begin
      r = s.zero;
    end else begin
      case (sel[1:0])
        `DSCP_SEL_STATUS: r = st;
        `DSCP_SEL_DATA:   r = s.data;
        `DSCP_SEL_CTRL:   r = s.ctrl;
        default:          r = `DSCP_REG_RESET;
      endcase
    end
    return r;
  endfunction

  // frame fields; msb arrives first so address sits on top
  assign addr = lnk_q.shift[`DSCP_ADDR_MSB:`DSCP_ADDR_LSB];
  assign word = lnk_q.shift[`DSCP_DATA_MSB:0];
  assign wdata = word & DATA_MASK;

  // ---------------------------------------------------------------
  // link side, rising edge: shift in data whatever the strobe does
  // ---------------------------------------------------------------
  always_comb begin
    lnk_d = lnk_q;
    // reset is brought into the link domain through two flops
    lnk_d.rst_m = rstn_i;
    lnk_d.rst_s = lnk_q.rst_m;
    // one bit per rising edge, first bit lands in the top slot
    lnk_d.shift = {lnk_q.shift[22:0], sdi_i};
    // bit count wraps per frame; only the readback uses it
    if (lnk_q.cnt == `DSCP_CNT_LAST) begin
      lnk_d.cnt = `DSCP_CNT_ZERO;
    end else begin
      lnk_d.cnt = lnk_q.cnt + 5'h01;
    end
    if (!lnk_q.rst_s) begin
      lnk_d.shift = `DSCP_SHIFT_RESET;
      lnk_d.cnt   = `DSCP_CNT_ZERO;
    end
  end

  // link rising edge flops
  always_ff @(posedge sclk_i) begin
    lnk_q <= lnk_d;
  end

  // ---------------------------------------------------------------
  // link side, falling edge: readback bit out, msb first
  // ---------------------------------------------------------------
  // rd_word only changes at a commit, while the link clock is idle,
  // so the link side may read it as a steady bus
  assign rd_frm = {`DSCP_RD_PAD, sys_q.rd_word};
  // falling edge k of a frame shows bit 24-k; count zero means the last
  assign rd_idx = (lnk_q.cnt == `DSCP_CNT_ZERO) ? `DSCP_CNT_ZERO
                                                 : 5'(5'd24 - lnk_q.cnt);

  always_comb begin
    neg_d = neg_q;
    neg_d.sdo = rd_frm[rd_idx];
    if (!lnk_q.rst_s) begin
      neg_d.sdo = 1'b0;
    end
  end

  // link falling edge flops
  always_ff @(negedge sclk_i) begin
    neg_q <= neg_d;
  end

  // ---------------------------------------------------------------
  // system side: commit strobe, decode and registers
  // ---------------------------------------------------------------
  always_comb begin
    sys_d = sys_q;
    // command pulses last one cycle
    sys_d.wdt  = 1'b0;
    sys_d.crc  = 1'b0;
    sys_d.srst = 1'b0;
    // strobe pin passes two flops before its edge is looked for
    sys_d.lat_m = latch_i;
    sys_d.lat_s = sys_q.lat_m;
    sys_d.lat_p = sys_q.lat_s;
    // rising strobe commits; shifter is steady because the host
    // holds the clock still around the strobe
    if (sys_q.lat_s && !sys_q.lat_p) begin
      case (addr)
        DSCP_DATA: begin
          sys_d.data = wdata;
        end
        DSCP_CTRL: begin
          sys_d.ctrl = word;
          // new range bits wipe the converter value
          if (word[`DSCP_RANGE_MSB:0] != sys_q.ctrl[`DSCP_RANGE_MSB:0]) begin
            sys_d.data = `DSCP_REG_RESET;
          end
        end
        DSCP_CFG: begin
          sys_d.cfg = word;
        end
        DSCP_GAIN: begin
          sys_d.gain = word;
        end
        DSCP_ZERO: begin
          sys_d.zero = word;
        end
        DSCP_RESET: begin
          // reset bit returns every register to its default
          if (word[`DSCP_RST_BIT]) begin
            sys_d.data    = `DSCP_REG_RESET;
            sys_d.ctrl    = `DSCP_REG_RESET;
            sys_d.cfg     = `DSCP_REG_RESET;
            sys_d.gain    = `DSCP_REG_RESET;
            sys_d.zero    = `DSCP_REG_RESET;
            sys_d.rd_word = `DSCP_REG_RESET;
            sys_d.srst    = 1'b1;
          end
        end
        DSCP_READ: begin
          // selected value waits for the next frame to clock it out
          sys_d.rd_word = rd_pick(word[`DSCP_SEL_MSB:0], sys_q,
                                  16'(status_i));
        end
        DSCP_WDT: begin
          sys_d.wdt = 1'b1;
        end
        DSCP_CRC: begin
          sys_d.crc = 1'b1;
        end
        DSCP_NOP: begin
          sys_d.data = sys_q.data;
        end
        default: begin
          sys_d.data = sys_q.data;
        end
      endcase
    end
    if (!rstn_i) begin
      sys_d         = '0;
      sys_d.data    = `DSCP_REG_RESET;
      sys_d.ctrl    = `DSCP_REG_RESET;
      sys_d.cfg     = `DSCP_REG_RESET;
      sys_d.gain    = `DSCP_REG_RESET;
      sys_d.zero    = `DSCP_REG_RESET;
      sys_d.rd_word = `DSCP_REG_RESET;
    end
  end

  // system domain flops
  always_ff @(posedge sys_clk_i) begin
    sys_q <= sys_d;
  end

  // outputs straight from flops
  assign sdo_o         = neg_q.sdo;
  assign data_o        = sys_q.data;
  assign ctrl_o        = sys_q.ctrl;
  assign cfg_o         = sys_q.cfg;
  assign gain_o        = sys_q.gain;
  assign zero_o        = sys_q.zero;
  assign wdt_restart_o = sys_q.wdt;
  assign crc_clear_o   = sys_q.crc;
  assign soft_reset_o  = sys_q.srst;
endmodule
`default_nettype wire

// *** pkg/dscp_defs.svh ***
// constants for the serial command port: codes, fields, reset values, timing
`ifndef DSCP_DEFS_SVH
`define DSCP_DEFS_SVH
`define DSCP_FRAME_BITS   24
`define DSCP_ADDR_MSB     23
`define DSCP_ADDR_LSB     16
`define DSCP_DATA_MSB     15
`define DSCP_CNT_LAST     5'h17
`define DSCP_CNT_ZERO     5'h00
`define DSCP_CMD_NOP      8'h00
`define DSCP_CMD_DATA     8'h01
`define DSCP_CMD_READ     8'h02
`define DSCP_CMD_CTRL     8'h55
`define DSCP_CMD_RESET    8'h56
`define DSCP_CMD_CFG      8'h57
`define DSCP_CMD_GAIN     8'h58
`define DSCP_CMD_ZERO     8'h59
`define DSCP_CMD_WDT      8'h95
`define DSCP_CMD_CRC      8'h96
`define DSCP_SEL_MSB      5
`define DSCP_SEL_STATUS   2'h0
`define DSCP_SEL_DATA     2'h1
`define DSCP_SEL_CTRL     2'h2
`define DSCP_SEL_CFG      6'h0b
`define DSCP_SEL_GAIN     6'h13
`define DSCP_SEL_ZERO     6'h17
`define DSCP_RST_BIT      0
`define DSCP_RANGE_MSB    2
`define DSCP_STATUS_BITS  5
`define DSCP_RES_BITS     16
`define DSCP_REG_RESET    16'h0000
`define DSCP_SHIFT_RESET  24'h00_0000
`define DSCP_RD_PAD       8'h00
`define DSCP_SCLK_MAX_MHZ 30
`define DSCP_SYS_MHZ      100
`endif

// *** pkg/dscp_pkg.sv ***
// types for the serial command port
`include "dscp_defs.svh"
package dscp_pkg;
  // address byte codes of a committed frame
  typedef enum logic [7:0] {
    DSCP_NOP   = `DSCP_CMD_NOP,
    DSCP_DATA  = `DSCP_CMD_DATA,
    DSCP_READ  = `DSCP_CMD_READ,
    DSCP_CTRL  = `DSCP_CMD_CTRL,
    DSCP_RESET = `DSCP_CMD_RESET,
    DSCP_CFG   = `DSCP_CMD_CFG,
    DSCP_GAIN  = `DSCP_CMD_GAIN,
    DSCP_ZERO  = `DSCP_CMD_ZERO,
    DSCP_WDT   = `DSCP_CMD_WDT,
    DSCP_CRC   = `DSCP_CMD_CRC
  } dscp_cmd_t;
  // system clock domain state
  typedef struct packed {
    logic        lat_m;
    logic        lat_s;
    logic        lat_p;
    logic [15:0] data;
    logic [15:0] ctrl;
    logic [15:0] cfg;
    logic [15:0] gain;
    logic [15:0] zero;
    logic [15:0] rd_word;
    logic        wdt;
    logic        crc;
    logic        srst;
  } dscp_sys_t;
  // link rising edge state
  typedef struct packed {
    logic        rst_m;
    logic        rst_s;
    logic [23:0] shift;
    logic [4:0]  cnt;
  } dscp_lnk_t;
  // link falling edge state
  typedef struct packed {
    logic sdo;
  } dscp_neg_t;
endpackage

// *** tb/dscp_top_asserts.sv ***
// checker for the serial command port outputs
`timescale 1ns/100ps
`default_nettype none
module dscp_top_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        latch_i,
  input wire logic [15:0] data_o,
  input wire logic [15:0] ctrl_o,
  input wire logic [15:0] cfg_o,
  input wire logic [15:0] gain_o,
  input wire logic [15:0] zero_o,
  input wire logic        wdt_restart_o,
  input wire logic        crc_clear_o,
  input wire logic        soft_reset_o
);
  logic [3:0] age_q; // cycles since strobe rose, saturating
  logic       lat_q; // strobe level at last edge
  // age of the last commit; raw strobe, so allow one cycle of sync slack
  always_ff @(posedge sys_clk_i) begin
    lat_q <= latch_i;
    if (!rstn_i) begin
      age_q <= 4'hf;
    end else if (latch_i && !lat_q) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_wdt_single: assert property (wdt_restart_o |=> !wdt_restart_o)
    else $error("watchdog pulse too long");
  a_crc_single: assert property (crc_clear_o |=> !crc_clear_o)
    else $error("crc clear pulse too long");
  a_srst_single: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  a_wdt_commit: assert property (wdt_restart_o |-> age_q inside {[1:4]})
    else $error("watchdog pulse without commit");
  a_crc_commit: assert property (crc_clear_o |-> age_q inside {[1:4]})
    else $error("crc clear pulse without commit");
  a_regs_commit: assert property (($changed(data_o) || $changed(ctrl_o) || $changed(cfg_o)
    || $changed(gain_o) || $changed(zero_o)) |-> age_q inside {[1:4]})
    else $error("register moved without commit");
  a_srst_clears: assert property (soft_reset_o |-> ##[0:1] ({data_o, ctrl_o, cfg_o, gain_o, zero_o} == '0))
    else $error("soft reset left a register set");
  a_range_clear: assert property ((ctrl_o[2:0] != $past(ctrl_o[2:0])) |-> (data_o == 16'h0000))
    else $error("range change kept converter data");
  c_wdt: cover property (wdt_restart_o);
  c_srst: cover property (soft_reset_o);
  c_range: cover property (ctrl_o[2:0] != $past(ctrl_o[2:0]));
endmodule
bind dscp_top dscp_top_asserts dscp_top_asserts_inst (.sys_clk_i, .rstn_i, .latch_i, .data_o, .ctrl_o,
  .cfg_o, .gain_o, .zero_o, .wdt_restart_o, .crc_clear_o, .soft_reset_o);
`default_nettype wire

// *** tb/dscp_host.sv ***
// host model: link master that shifts frames and commits them
`timescale 1ns/100ps
`default_nettype none
module dscp_host (
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      latch_o
);
  // one device per clock, so no gating needed here
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    latch_o = 1'b0;
  end
  // free clocks, only used around reset
  task automatic idle(input int n);
    repeat (n) begin
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
  endtask
  // one frame msb first, sdo sampled before each rise after the first and once after the last fall; gap pauses clock
  task automatic frame(input logic [23:0] f, input int gap, output logic [23:0] rd);
    for (int k = 23; k >= 0; k--) begin
      sdi_o = f[k];
      if (k == 11) #(gap); // burst clocking
      #7.5 if (k < 23) rd = {rd[22:0], sdo_i};
      sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    #7.5 rd = {rd[22:0], sdo_i};
    sdi_o = ~f[0]; // released line shows the inverse
    #40 latch_o = 1'b1; // strobe after exactly 24 edges
    #40 latch_o = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench for the serial command port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dscp_pkg::*;
  logic        sys_clk_i, rstn_i, sclk, sdi, latch, sdo, wdt, crc, srst;
  logic [4:0]  status;
  logic [15:0] data, ctrl, cfg, gain, zero;
  logic [23:0] rd;
  logic [7:0]  adr [5] = '{8'h55, 8'h01, 8'h57, 8'h58, 8'h59};
  logic [5:0]  sel [5] = '{6'h06, 6'h3d, 6'h0b, 6'h13, 6'h17};
  logic [15:0] val [5] = '{16'h1006, 16'ha5c3, 16'h003c, 16'h8001, 16'h7ffe};
  int          bad_count, n_compared, cyc, nw, nc, ns;
  dscp_top dscp_top_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdi_i(sdi),
    .latch_i(latch), .status_i(status), .sdo_o(sdo), .data_o(data), .ctrl_o(ctrl), .cfg_o(cfg),
    .gain_o(gain), .zero_o(zero), .wdt_restart_o(wdt), .crc_clear_o(crc), .soft_reset_o(srst));
  dscp_host dscp_host_inst (.sdo_i(sdo), .sclk_o(sclk), .sdi_o(sdi), .latch_o(latch));
  // clock, pulse counting and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    nw += wdt;
    nc += crc;
    ns += srst;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] a, input logic [15:0] d, input int gap = 0);
    dscp_host_inst.frame({a, d}, gap, rd);
  endtask
  // read request with junk in bits 15..6, then a no-op clocks it out
  task automatic rdreg(input logic [5:0] s, input logic [15:0] exp);
    send(DSCP_READ, {10'h3ff, s});
    send(DSCP_NOP, 16'h0000);
    check(80'(rd), 80'({8'h00, exp}));
  endtask
  // all writable registers, then read each back
  task automatic t_writes();
    foreach (adr[i]) send(adr[i], val[i]);
    check({ctrl, data, cfg, gain, zero}, {val[0], val[1], val[2], val[3], val[4]});
    foreach (sel[i]) rdreg(sel[i], val[i]);
  endtask
  // commands and unknown codes leave registers alone
  task automatic t_cmds();
    send(DSCP_NOP, 16'hffff);
    send(DSCP_WDT, 16'hffff);
    send(DSCP_CRC, 16'hffff);
    send(8'h33, 16'hffff);
    send(DSCP_RESET, 16'hfffe);
    check({ctrl, data, cfg, gain, zero}, {val[0], val[1], val[2], val[3], val[4]});
    check(80'({16'(nw), 16'(nc), 16'(ns)}), 80'({16'd1, 16'd1, 16'd0}));
  endtask
  // same range keeps data, new range clears it; paused clock mid frame
  task automatic t_range();
    send(DSCP_CTRL, 16'h1016, 200);
    check(80'(data), 80'(val[1]));
    send(DSCP_CTRL, 16'h1017);
    check(80'({ctrl, data}), 80'({16'h1017, 16'h0000}));
  endtask
  // soft reset clears every register
  task automatic t_soft();
    send(DSCP_RESET, 16'h0001);
    check({ctrl, data, cfg, gain, zero}, '0);
    check(80'(ns), 80'(1));
  endtask
  initial begin
    rstn_i = 1'b0;
    status = 5'h15;
    fork
      dscp_host_inst.idle(4);
      repeat (2) @(negedge sys_clk_i);
    join
    @(negedge sys_clk_i) rstn_i = 1'b1;
    // exactly two link edges let the reset sync settle with the bit
    // counter still at zero; any more would skew the readback framing
    dscp_host_inst.idle(2);
    check({ctrl, data, cfg, gain, zero}, '0);
    rdreg(6'h3c, 16'h0015);
    t_writes();
    t_cmds();
    t_range();
    t_soft();
    complete_run();
  end
endmodule
`default_nettype wire
